// ---- hw/apm_power_ctl.sv ----
// Power mode control for a two-converter sampling unit and its shared reference.
// Assumes a scan sequencer that requests scans, waits for scan_go and reports busy,
// and software that keeps the manual power-up wait before starting a scan.
//
// Summary of operation
// [R1] Active while any converter runs a scan
// [R2] Standby current only at 100kHz standby clock
// [R3] One shared current mode, same cycle count
// [R4] Current mode changes only while idle
// [R5] Auto power-down overrides auto standby
// [R6] Auto standby idle: standby clock, standby current
// [R7] Auto standby start: conversion clock, delay, scan
// [R8] Back to idle restores standby clock, current
// [R9] Reference status reads 1 when powered down
// [R10] Converter B status: set now, clear delayed
// [R11] Converter A status behaves the same
// [R12] Six-bit power-up delay, reset value 13
// [R13] Auto power-down powers converters per scan
// [R14] Mode change mid-scan waits for idle
// [R15] Looping scans never reach low power
// [R16] Reference forced on, or follows converters
// [R17] Converter B power-down bit forces off
// [R18] Converter A power-down bit forces off
// [R19] Software waits delay after manual power-up
// [R20] Reference source select bits 15, 14
// [R21] Reserved bits read zero, ignore writes
// [R22] Delay counter, zero means no delay
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module apm_power_ctl
  import apm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire apm_req_s req_i,
  output logic [DATA_W-1:0] rdata_o,
  // Scan sequencer
  input wire logic scan_req_i,
  input wire logic scan_need_a_i,
  input wire logic scan_need_b_i,
  input wire logic scan_busy_i,
  output logic scan_go_o,
  output logic unit_active_o,
  // Analog side
  output apm_pwr_s pwr_o,
  output logic conv_tick_o,
  output logic high_ref_select_o,
  output logic low_ref_select_o
);

  logic auto_standby_en_r;
  logic auto_powerdown_en_r;
  logic [5:0] powerup_delay_cycles_r;
  logic refgen_powerdown_ctl_r;
  logic [1:0] pd_r;
  logic [5:0] pu_cnt_r [2];
  logic [5:0] wake_cnt_r;
  logic [8:0] div_cnt_r;
  logic [1:0] need_r;
  logic seen_busy_r;
  logic [DATA_W-1:0] rdata_r;
  apm_state_e st_r, st_nxt;
  apm_pwr_s pwr_r;
  logic scan_go_r, active_r, tick_r, href_r, lref_r;
  logic wr_pwr, wr_ref;
  logic [1:0] wr_pd, conv_sts;
  logic stby_sel;

  // Register decode
  assign wr_pwr = req_i.wr && (req_i.addr == PWR_ADDR);
  assign wr_ref = req_i.wr && (req_i.addr == REF_ADDR);
  assign wr_pd = {req_i.wdata[B_PD_B], req_i.wdata[B_PD_A]};
  // Auto standby only counts when auto power-down is off
  assign stby_sel = auto_standby_en_r && !auto_powerdown_en_r; // [R5]

  // Power control register, writable fields only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      auto_standby_en_r <= 1'b0;
      auto_powerdown_en_r <= 1'b0;
      powerup_delay_cycles_r <= DLY_RST; // [R12]
      refgen_powerdown_ctl_r <= 1'b1;
      pd_r <= 2'b11;
    end else if (wr_pwr) begin
      auto_standby_en_r <= req_i.wdata[B_ASB];
      auto_powerdown_en_r <= req_i.wdata[B_APD];
      powerup_delay_cycles_r <= req_i.wdata[B_DLY_HI:B_DLY_LO];
      refgen_powerdown_ctl_r <= req_i.wdata[B_PD_REF];
      pd_r <= wr_pd; // [R17] [R18]
    end
  end

  // Reference select register; bits 13-0 have no storage
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      href_r <= 1'b0;
      lref_r <= 1'b0;
    end else if (wr_ref) begin
      href_r <= req_i.wdata[B_HREF]; // [R20]
      lref_r <= req_i.wdata[B_LREF]; // [R20]
    end
  end

  // Converter clock enable; the divider follows the selected clock source
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_cnt_r <= 9'h000;
      tick_r <= 1'b0;
    end else if (div_cnt_r >= (pwr_r.standby_clk ? STBY_DIV : CONV_DIV) - 9'h001) begin
      div_cnt_r <= 9'h000; // [R2]
      tick_r <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 9'h001;
      tick_r <= 1'b0;
    end
  end

  // Manual power-up timers; a clear of a power-down bit starts the wait
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < 2; i++) begin
        pu_cnt_r[i] <= 6'h00;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_pwr && pd_r[i] && !wr_pd[i]) begin
          // Take the delay from the same write, so a new delay and a power-up can share one access
          pu_cnt_r[i] <= req_i.wdata[B_DLY_HI:B_DLY_LO]; // [R22]
        end else if (wr_pwr && wr_pd[i]) begin
          pu_cnt_r[i] <= 6'h00;
        end else if (tick_r && pu_cnt_r[i] != 6'h00) begin
          pu_cnt_r[i] <= pu_cnt_r[i] - 6'h01; // [R22]
        end
      end
    end
  end

  // Status: set at once by a power-down write, clears after the timer, or
  // follows the real power state under auto power-down
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (pd_r[i]) begin
        conv_sts[i] = 1'b1;
      end else if (auto_powerdown_en_r) begin
        conv_sts[i] = i == 0 ? !pwr_r.conv_a_on : !pwr_r.conv_b_on;
      end else begin
        conv_sts[i] = pu_cnt_r[i] != 6'h00; // [R10] [R11]
      end
    end
  end

  // Scan start sequencing; a zero delay skips the wake state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      APM_IDLE: begin
        if (scan_req_i) begin
          if ((auto_powerdown_en_r || auto_standby_en_r) && powerup_delay_cycles_r != 6'h00) begin
            st_nxt = APM_WAKE; // [R7] [R13]
          end else begin
            st_nxt = APM_ACT;
          end
        end
      end
      APM_WAKE: begin
        if (tick_r && wake_cnt_r == 6'h00) begin
          st_nxt = APM_ACT;
        end
      end
      APM_ACT: begin
        // Looping scans keep busy high and so never leave here
        if (seen_busy_r && !scan_busy_i) begin
          st_nxt = APM_IDLE; // [R14] [R15]
        end
      end
      default: st_nxt = APM_IDLE;
    endcase
  end

  // State, wake counter and scan permission
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= APM_IDLE;
      wake_cnt_r <= 6'h00;
      scan_go_r <= 1'b0;
      need_r <= 2'b00;
    end else begin
      st_r <= st_nxt;
      scan_go_r <= st_r != APM_ACT && st_nxt == APM_ACT; // [R7]
      if (st_r == APM_IDLE && scan_req_i) begin
        need_r <= {scan_need_b_i, scan_need_a_i};
        wake_cnt_r <= powerup_delay_cycles_r - 6'h01; // [R22]
      end else if (st_r == APM_WAKE && tick_r && wake_cnt_r != 6'h00) begin
        wake_cnt_r <= wake_cnt_r - 6'h01;
      end
    end
  end

  // Busy seen since the scan was released; guards the return to idle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seen_busy_r <= 1'b0;
      active_r <= 1'b0;
    end else begin
      seen_busy_r <= st_nxt == APM_ACT && (seen_busy_r || scan_busy_i);
      active_r <= st_nxt != APM_IDLE || scan_busy_i; // [R1]
    end
  end

  // Analog controls follow the next state so they line up with it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwr_r <= '0;
    end else begin
      // One shared current mode, moved only while idle
      pwr_r.standby_current <= st_nxt == APM_IDLE && stby_sel; // [R3] [R4] [R6] [R8]
      pwr_r.standby_clk <= st_nxt == APM_IDLE && stby_sel; // [R6] [R8]
      pwr_r.conv_a_on <= !pd_r[0] && !(wr_pwr && wr_pd[0]) &&
        (!auto_powerdown_en_r || (st_nxt != APM_IDLE &&
        (st_r == APM_IDLE ? scan_need_a_i : need_r[0]))); // [R13] [R18]
      pwr_r.conv_b_on <= !pd_r[1] && !(wr_pwr && wr_pd[1]) &&
        (!auto_powerdown_en_r || (st_nxt != APM_IDLE &&
        (st_r == APM_IDLE ? scan_need_b_i : need_r[1]))); // [R13] [R17]
      pwr_r.ref_on <= !refgen_powerdown_ctl_r || pwr_r.conv_a_on || pwr_r.conv_b_on; // [R16]
    end
  end

  // Read data, one cycle after the strobe; reserved bits stay zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_r <= 16'h0000;
    end else if (req_i.rd && req_i.addr == PWR_ADDR) begin
      rdata_r <= 16'h0000; // [R21]
      rdata_r[B_ASB] <= auto_standby_en_r;
      rdata_r[B_REF_STS] <= !pwr_r.ref_on; // [R9]
      rdata_r[B_B_STS] <= conv_sts[1]; // [R10]
      rdata_r[B_A_STS] <= conv_sts[0]; // [R11]
      rdata_r[B_DLY_HI:B_DLY_LO] <= powerup_delay_cycles_r;
      rdata_r[B_APD] <= auto_powerdown_en_r;
      rdata_r[B_PD_REF] <= refgen_powerdown_ctl_r;
      rdata_r[B_PD_B:B_PD_A] <= pd_r;
    end else if (req_i.rd && req_i.addr == REF_ADDR) begin
      rdata_r <= {href_r, lref_r, 14'h0000}; // [R21]
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // Outputs straight from flip-flops
  assign rdata_o = rdata_r;
  assign scan_go_o = scan_go_r;
  assign unit_active_o = active_r;
  assign pwr_o = pwr_r;
  assign conv_tick_o = tick_r;
  assign high_ref_select_o = href_r;
  assign low_ref_select_o = lref_r;

  // Checks on the design's own outputs and internal state
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  active_busy_a: assert property ( // [R1]
    scan_busy_i |=> active_r
  ) else $error("unit not active while busy");

  stby_idle_a: assert property ( // [R6]
    (st_r == APM_IDLE && stby_sel && $past(stby_sel) && $past(st_r) == APM_IDLE) |->
      pwr_r.standby_current && pwr_r.standby_clk
  ) else $error("standby not held while idle");

  no_stby_scan_a: assert property ( // [R4]
    st_r != APM_IDLE |-> !pwr_r.standby_current && !pwr_r.standby_clk
  ) else $error("standby current during scan");

  apd_prec_a: assert property ( // [R5]
    $past(auto_powerdown_en_r) && auto_powerdown_en_r |-> !pwr_r.standby_current
  ) else $error("standby under auto power-down");

  wake_load_a: assert property ( // [R22]
    $rose(st_r == APM_WAKE) |-> wake_cnt_r == $past(powerup_delay_cycles_r) - 6'h01
  ) else $error("wake counter not loaded from delay");

  wake_go_a: assert property ( // [R7]
    (st_r == APM_WAKE && tick_r && wake_cnt_r == 6'h00) |=> st_r == APM_ACT ##0 scan_go_r
  ) else $error("scan not released after delay");

  ref_force_a: assert property ( // [R16]
    !refgen_powerdown_ctl_r |=> pwr_r.ref_on
  ) else $error("reference not forced on");

  pd_b_off_a: assert property ( // [R17]
    (wr_pwr && wr_pd[1]) |=> !pwr_r.conv_b_on && conv_sts[1]
  ) else $error("converter b not off after power-down write");

  pd_a_off_a: assert property ( // [R18]
    (wr_pwr && wr_pd[0]) |=> !pwr_r.conv_a_on && conv_sts[0]
  ) else $error("converter a not off after power-down write");

  rsvd_zero_a: assert property ( // [R21]
    req_i.rd |=> rdata_r[13:0] == 14'h0000 || $past(req_i.addr) == PWR_ADDR && rdata_r[14:13] == 2'b00
  ) else $error("reserved bits read nonzero");

endmodule

// ---- hw/apm_pkg.sv ----
// Package for the converter power mode control block.
// Assumes one 50 MHz clock; converter clocks are enable pulses from a divider.
package apm_pkg;
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  // Register indices and byte addresses (byte address = 4 * index)
  localparam logic [23:0] PWR_IDX = 24'h19_0029;
  localparam logic [23:0] REF_IDX = 24'h19_002A;
  localparam logic [ADDR_W-1:0] PWR_ADDR = {PWR_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] REF_ADDR = {REF_IDX, 2'b00};
  // Power control field positions
  localparam int B_ASB = 15;
  localparam int B_REF_STS = 12;
  localparam int B_B_STS = 11;
  localparam int B_A_STS = 10;
  localparam int B_DLY_HI = 9;
  localparam int B_DLY_LO = 4;
  localparam int B_APD = 3;
  localparam int B_PD_REF = 2;
  localparam int B_PD_B = 1;
  localparam int B_PD_A = 0;
  // Reference select field positions
  localparam int B_HREF = 15;
  localparam int B_LREF = 14;
  // Value after reset and register write masks
  localparam logic [5:0] DLY_RST = 6'h0D;
  localparam logic [DATA_W-1:0] PWR_WR_MASK = 16'h83FF;
  localparam logic [DATA_W-1:0] REF_WR_MASK = 16'hC000;
  // Clock rates and converter clock dividers
  localparam int CLK_HZ = 50_000_000;
  localparam int STBY_HZ = 100_000;
  localparam int CONV_HZ = 5_000_000;
  localparam logic [8:0] STBY_DIV = 9'(CLK_HZ / STBY_HZ);
  localparam logic [8:0] CONV_DIV = 9'(CLK_HZ / CONV_HZ);
  // Scan sequencing states
  typedef enum logic [2:0] {
    APM_IDLE = 3'b001,
    APM_WAKE = 3'b010,
    APM_ACT = 3'b100
  } apm_state_e;
  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } apm_req_s;
  // Analog side power controls
  typedef struct packed {
    logic conv_a_on;
    logic conv_b_on;
    logic ref_on;
    logic standby_current;
    logic standby_clk;
  } apm_pwr_s;
endpackage

// ---- testbench/apm_seq_model.sv ----
// Scan sequencer model facing the power control block.
// Assumes scan_go is a one-cycle pulse; the bench sets the scan length.
`timescale 1ns/1ps
module apm_seq_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Scan handshake
  input wire logic scan_go,
  input wire logic [7:0] scan_len,
  output logic scan_busy
);
  logic [7:0] cnt_r;
  // Busy from the edge after go until the length runs out, so active must hold
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scan_busy <= 1'b0;
      cnt_r <= 8'h00;
    end else if (scan_go) begin
      scan_busy <= 1'b1;
      cnt_r <= scan_len;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else begin
      scan_busy <= 1'b0;
    end
  end
endmodule

// ---- testbench/tb.sv ----
// Bench for the converter power mode control block.
// Assumes the sequencer model; a converter clock every 10 cycles when converting.
`timescale 1ns/1ps
module tb;
  import apm_pkg::*;
  logic ref_clk, reset, scan_req, need_a, need_b, scan_go, active, tick, hsel, lsel, busy;
  apm_req_s req;
  apm_pwr_s power_control;
  logic [DATA_W-1:0] v, w;
  logic [7:0] blen;
  int error_cnt, n_checks, c, k;

  apm_power_ctl u_apm_power_ctl (.ref_clk(ref_clk), .reset(reset), .req_i(req), .rdata_o(v),
    .scan_req_i(scan_req), .scan_need_a_i(need_a), .scan_need_b_i(need_b), .scan_busy_i(busy),
    .scan_go_o(scan_go), .unit_active_o(active), .pwr_o(power_control), .conv_tick_o(tick),
    .high_ref_select_o(hsel), .low_ref_select_o(lsel));
  apm_seq_model u_apm_seq_model (.ref_clk(ref_clk), .reset(reset), .scan_go(scan_go),
    .scan_len(blen), .scan_busy(busy));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Bus tasks open on a fresh edge so a strobe is never set and cleared in one step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 d = v;
  endtask
  // Software keeps the power-up wait by polling status
  task automatic poll(input logic [15:0] e);
    c = 0;
    w = 16'hFFFF;
    while (w !== e && c < 600) begin
      rd(PWR_ADDR, w);
      c++;
    end
    chk("pwr_poll", e, w);
  endtask
  // Start a scan and time scan_go; d is the delay in auto modes, 0 in manual
  task automatic go(input logic a, input logic b, input int d);
    @(posedge ref_clk);
    scan_req <= 1'b1;
    need_a <= a;
    need_b <= b;
    @(posedge ref_clk);
    scan_req <= 1'b0;
    c = 0;
    #1;
    while (scan_go !== 1'b1 && c < 1000) begin
      @(posedge ref_clk);
      #1 c++;
    end
    chk("go_lat", 16'h1, 16'(c >= (d > 0 ? (d - 1) * 10 : 0) && c <= d * 10 + 2));
  endtask
  task automatic idle();
    c = 0;
    while (active !== 1'b0 && c < 1000) begin
      @(posedge ref_clk);
      #1 c++;
    end
    if (c >= 1000) begin
      error_cnt++;
      final_report();
    end
    @(posedge ref_clk);
    #1;
  endtask

  // Free-running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    reset = 1'b1;
    req = '0;
    scan_req = 1'b0;
    need_a = 1'b0;
    need_b = 1'b0;
    blen = 8'h14;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(32'haa8a5694));
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    // Reset values: all down, delay 13, reference off
    rd(PWR_ADDR, w);
    chk("pwr_rst", 16'h1CD7, w);
    rd(REF_ADDR, w);
    chk("ref_rst", 16'h0000, w);
    chk("ref_on", 16'h0, 16'(power_control.ref_on));
    // Reference select with random data, reserved bits and an unmapped place
    repeat (4) begin
      k = $urandom;
      wr(REF_ADDR, 16'(k));
      rd(REF_ADDR, w);
      chk("ref_rw", 16'(k) & REF_WR_MASK, w);
      chk("ref_sel", 16'(k[15:14]), {14'h0, hsel, lsel});
    end
    rd(REF_ADDR + 26'h4, w);
    chk("unmapped", 16'h0000, w);
    $display("test registers done");
    // Manual power-up, delay 2: status stays set until the delay runs out
    k = $urandom;
    wr(PWR_ADDR, (16'(k) & 16'h6000) | 16'h0020);
    rd(PWR_ADDR, w);
    chk("sts_hold", 16'h0C20, w);
    poll(16'h0020);
    chk("on", 16'h7, {13'h0, power_control.conv_a_on, power_control.conv_b_on, power_control.ref_on});
    wr(PWR_ADDR, 16'h0021);
    rd(PWR_ADDR, w);
    chk("pd_a", 16'h0421, w);
    wr(PWR_ADDR, 16'h0027);
    rd(PWR_ADDR, w);
    chk("pd_all", 16'h1C27, w);
    chk("all_off", 16'h0, {13'h0, power_control.conv_a_on, power_control.conv_b_on, power_control.ref_on});
    $display("test manual done");
    // Auto standby: standby while idle, conversion clock during scans
    wr(PWR_ADDR, 16'h8020);
    poll(16'h8020);
    repeat (3) begin
      blen = 8'(8'h10 + $urandom % 32);
      chk("stby_idle", 16'h3, {14'h0, power_control.standby_clk, power_control.standby_current});
      go(1'b1, 1'b1, 2);
      chk("stby_go", 16'h0, {14'h0, power_control.standby_clk, power_control.standby_current});
      @(posedge ref_clk);
      #1 chk("cur_busy", 16'h1, {15'h0, active & ~power_control.standby_current});
      idle();
      chk("stby_back", 16'h3, {14'h0, power_control.standby_clk, power_control.standby_current});
    end
    $display("test standby done");
    // Auto power-down beside standby: only the needed converters wake
    wr(PWR_ADDR, 16'h8028);
    repeat (4) @(posedge ref_clk);
    #1 chk("apd_idle", 16'h0, {13'h0, power_control.standby_clk, power_control.conv_a_on, power_control.conv_b_on});
    for (k = 1; k < 4; k++) begin
      go(k[0], k[1], 2);
      chk("apd_on", 16'(k), {14'h0, power_control.conv_b_on, power_control.conv_a_on});
      idle();
      chk("apd_off", 16'h0, {14'h0, power_control.conv_b_on, power_control.conv_a_on});
      rd(PWR_ADDR, w);
      chk("apd_sts", 16'h8C28, w);
    end
    $display("test powerdown done");
    // Auto standby set mid-scan only takes hold once idle
    wr(PWR_ADDR, 16'h0020);
    poll(16'h0020);
    blen = 8'h40;
    go(1'b1, 1'b0, 0);
    wr(PWR_ADDR, 16'h8020);
    repeat (8) @(posedge ref_clk);
    #1 chk("mid_scan", 16'h1, {14'h0, power_control.standby_clk, active});
    idle();
    chk("after_scan", 16'h3, {14'h0, power_control.standby_clk, power_control.standby_current});
    $display("test midscan done");
    final_report();
  end
endmodule
